// File: rtl/rls_pkg.sv
// Purpose: Constants and types for the receive list status word block
// Assumes: 32-bit APB, byte addresses on PADDR
// Notes:   Register offsets are byte addresses of aligned words
package rls_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_CMD   = 8'h04;
  localparam logic [7:0]  OFS_HEAD  = 8'h08;
  localparam logic [7:0]  OFS_STAT  = 8'h0c;
  localparam logic [7:0]  OFS_MASK  = 8'h10;
  localparam logic [7:0]  OFS_NEXT  = 8'h14;

  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CMD_RECHECK_BIT = 0;
  localparam int          CMD_RESUME_BIT  = 1;
  localparam int          ST_FRAME_BIT    = 0;
  localparam int          ST_PAUSE_BIT    = 1;
  localparam int          NEXT_PAUSED_BIT = 0;

  localparam logic        RST_EN     = 1'b0;
  localparam logic [31:0] RST_HEAD   = 32'h0000_0000;
  localparam logic [1:0]  RST_STAT   = 2'h0;
  localparam logic [1:0]  RST_MASK   = 2'h0;

  // ------------------------------------------------------------------
  // List status word fields
  // ------------------------------------------------------------------
  localparam int          LSW_VALID    = 0;
  localparam int          LSW_COMPLETE = 1;
  localparam int          LSW_START    = 2;
  localparam int          LSW_END      = 3;
  localparam int          LSW_FRM_IRQ  = 4;
  localparam int          LSW_PAUSE    = 5;
  localparam int          LSW_FSB_LO   = 8;
  localparam int          LSW_FSB_HI   = 13;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_HALT, ST_FILL, ST_WB_START, ST_WB_END, ST_PAUSE
  } rls_state_t;

  // Fetched list: its address, status word and link field
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] word;
    logic [31:0] link;
  } rls_list_t;

  // Data mover report for one filled list
  typedef struct packed {
    logic        sof;
    logic        eof;
    logic [7:0]  fsb;
  } rls_fill_t;

  // Completion write-back of one list status word
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] word;
  } rls_wb_t;

endpackage : rls_pkg

// File: rtl/rls_cmp_word.sv
// Purpose: Builds the completion list status word for one list
// Assumes: Caller says whether the list starts and/or ends the frame
// Notes:   Pure combinational
`timescale 1ns/1ps
module rls_cmp_word (
  input  wire logic        is_start,
  input  wire logic        is_end,
  input  wire logic [7:0]  frame_status_byte,
  output logic [15:0]      list_status_word
);
  import rls_pkg::*;

  always_comb begin
    list_status_word = 16'h0000;
    list_status_word[LSW_VALID]    = 1'b0;
    list_status_word[LSW_COMPLETE] = 1'b1;
    list_status_word[LSW_START]    = is_start;
    list_status_word[LSW_END]      = is_end;
    if (is_start) begin
      list_status_word[LSW_FSB_HI:LSW_FSB_LO] = frame_status_byte[7:2];
    end else begin
      list_status_word[LSW_FSB_HI:LSW_FSB_LO] = 6'h00;
    end
  end

endmodule : rls_cmp_word

// File: rtl/rls_top.sv
// Purpose: Receive list status word engine with APB registers
// Assumes: Fetcher and data mover outside; all inputs synchronous to MCLK
// Notes:   Rewrites start and end lists of each frame after the frame is moved
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module rls_top (
  input  wire logic              MCLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic                   IRQ,
  output logic                   FETCH_REQ,
  output logic [31:0]            FETCH_ADDR,
  input  wire logic              LIST_RSP,
  input  wire rls_pkg::rls_list_t LIST_IN,
  output logic                   FILL_GO,
  input  wire logic              FILL_DONE,
  input  wire rls_pkg::rls_fill_t FILL_IN,
  output logic                   WB_REQ,
  output rls_pkg::rls_wb_t       WB_OUT,
  input  wire logic              WB_ACK
);
  import rls_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    rls_state_t  st;
    logic        en;
    logic [31:0] head;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        fetch_req;
    logic [31:0] fetch_addr;
    logic [15:0] cur_word;
    logic [31:0] cur_link;
    logic        fill_go;
    logic        start_irq;
    logic        start_pause;
    logic [7:0]  fsb;
    logic [31:0] start_addr;
    logic [31:0] end_addr;
    logic [31:0] end_link;
    logic        end_sof;
    logic        wb_req;
    rls_wb_t     wb;
  } rls_regs_t;

  rls_regs_t   s_r;
  rls_regs_t   s_nxt;
  logic [15:0] start_word;
  logic [15:0] end_word;
  logic        acc;
  logic        wr;
  logic        recheck;
  logic        resume;
  logic        wb_done;
  logic        map_hit;
  logic [31:0] rd_val;
  logic        fill_take;
  logic        start_end;
  logic [7:0]  start_fsb;

  // ------------------------------------------------------------------
  // Completion words
  // ------------------------------------------------------------------
  rls_cmp_word u_start_word (
    .is_start          (1'b1),
    .is_end            (start_end),
    .frame_status_byte (start_fsb),
    .list_status_word  (start_word)
  );

  rls_cmp_word u_end_word (
    .is_start          (1'b0),
    .is_end            (1'b1),
    .frame_status_byte (s_r.fsb),
    .list_status_word  (end_word)
  );

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  always_comb begin
    acc     = PSEL && PENABLE && s_r.pready;
    wr      = acc && PWRITE;
    recheck = wr && (PADDR == OFS_CMD) && PWDATA[CMD_RECHECK_BIT];
    resume  = wr && (PADDR == OFS_CMD) && PWDATA[CMD_RESUME_BIT];
    // Start word holds this frame's flags in the cycle the request rises
    fill_take = (s_r.st == ST_FILL) && FILL_DONE;
    start_end = fill_take ? FILL_IN.sof : s_r.end_sof;
    start_fsb = (fill_take && FILL_IN.sof) ? FILL_IN.fsb : s_r.fsb;
    wb_done = s_r.wb_req && WB_ACK &&
              ((s_r.st == ST_WB_END) || ((s_r.st == ST_WB_START) && s_r.end_sof));
    map_hit = 1'b1;
    rd_val  = 32'h0000_0000;
    unique case (PADDR)
      OFS_CTRL: rd_val[CTRL_EN_BIT] = s_r.en;
      OFS_CMD:  rd_val = 32'h0000_0000;
      OFS_HEAD: rd_val = s_r.head;
      OFS_STAT: rd_val[1:0] = s_r.stat;
      OFS_MASK: rd_val[1:0] = s_r.mask;
      OFS_NEXT: rd_val = {s_r.fetch_addr[31:1], s_r.st == ST_PAUSE};
      default:  map_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = PSEL && PENABLE && !s_r.pready;
    if (PSEL && PENABLE && !s_r.pready) begin
      s_nxt.prdata  = PWRITE ? 32'h0000_0000 : rd_val;
      s_nxt.pslverr = !map_hit;
    end
    if (wr && PADDR == OFS_CTRL) begin
      s_nxt.en = PWDATA[CTRL_EN_BIT];
    end
    if (wr && PADDR == OFS_HEAD) begin
      s_nxt.head = PWDATA;
    end
    if (wr && PADDR == OFS_MASK) begin
      s_nxt.mask = PWDATA[1:0];
    end
    // Only bits returned by the read are cleared
    if (acc && !PWRITE && PADDR == OFS_STAT) begin
      s_nxt.stat = s_r.stat & ~s_r.prdata[1:0];
    end
    s_nxt.fill_go = 1'b0;

    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.en) begin
          s_nxt.fetch_addr = s_r.head;
          s_nxt.fetch_req  = 1'b1;
          s_nxt.st         = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (LIST_RSP) begin
          s_nxt.fetch_req = 1'b0;
          s_nxt.cur_word  = LIST_IN.word;
          s_nxt.cur_link  = LIST_IN.link;
          if (LIST_IN.word[LSW_VALID]) begin
            s_nxt.fill_go = 1'b1;
            s_nxt.st      = ST_FILL;
          end else begin
            s_nxt.st = ST_HALT;
          end
        end
      end
      ST_HALT: begin
        // No status bit is raised while halted
        if (!s_r.en) begin
          s_nxt.st = ST_IDLE;
        end else if (recheck) begin
          s_nxt.fetch_req = 1'b1;
          s_nxt.st        = ST_FETCH;
        end
      end
      ST_FILL: begin
        if (FILL_DONE) begin
          if (FILL_IN.sof) begin
            s_nxt.start_addr  = s_r.fetch_addr;
            s_nxt.start_irq   = s_r.cur_word[LSW_FRM_IRQ];
            s_nxt.start_pause = s_r.cur_word[LSW_PAUSE];
            s_nxt.fsb         = FILL_IN.fsb;
          end
          if (FILL_IN.eof) begin
            s_nxt.end_addr = s_r.fetch_addr;
            s_nxt.end_link = s_r.cur_link;
            s_nxt.end_sof  = FILL_IN.sof;
            s_nxt.wb_req   = 1'b1;
            s_nxt.wb.addr  = FILL_IN.sof ? s_r.fetch_addr : s_r.start_addr;
            s_nxt.st       = ST_WB_START;
          end else begin
            s_nxt.fetch_addr = s_r.cur_link;
            s_nxt.fetch_req  = 1'b1;
            s_nxt.st         = ST_FETCH;
          end
        end
      end
      ST_WB_START: begin
        if (WB_ACK && !s_r.end_sof) begin
          s_nxt.wb.addr = s_r.end_addr;
          s_nxt.st      = ST_WB_END;
        end
      end
      ST_WB_END: begin
      end
      ST_PAUSE: begin
        if (!s_r.en) begin
          s_nxt.st = ST_IDLE;
        end else if (resume) begin
          s_nxt.fetch_req = 1'b1;
          s_nxt.st        = ST_FETCH;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    s_nxt.wb.word = (s_nxt.st == ST_WB_END) ? end_word : start_word;

    if (wb_done) begin
      s_nxt.wb_req     = 1'b0;
      s_nxt.fetch_addr = s_r.end_link;
      if (s_r.start_irq || s_r.start_pause) begin
        s_nxt.stat[ST_FRAME_BIT] = 1'b1;
      end
      if (s_r.start_pause) begin
        s_nxt.stat[ST_PAUSE_BIT] = 1'b1;
        s_nxt.st                 = ST_PAUSE;
      end else begin
        s_nxt.fetch_req = 1'b1;
        s_nxt.st        = ST_FETCH;
      end
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r      <= '0;
      s_r.st   <= ST_IDLE;
      s_r.en   <= RST_EN;
      s_r.head <= RST_HEAD;
      s_r.stat <= RST_STAT;
      s_r.mask <= RST_MASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign PRDATA     = s_r.prdata;
  assign PREADY     = s_r.pready;
  assign PSLVERR    = s_r.pslverr;
  assign IRQ        = s_r.irq;
  assign FETCH_REQ  = s_r.fetch_req;
  assign FETCH_ADDR = s_r.fetch_addr;
  assign FILL_GO    = s_r.fill_go;
  assign WB_REQ     = s_r.wb_req;
  assign WB_OUT     = s_r.wb;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  sequence seq_list_taken;
    s_r.st == ST_FETCH && LIST_RSP;
  endsequence

  sequence seq_frame_done;
    s_r.wb_req && WB_ACK &&
    ((s_r.st == ST_WB_END) || (s_r.st == ST_WB_START && s_r.end_sof));
  endsequence

  a_invalid_halts: assert property (seq_list_taken ##0 !LIST_IN.word[LSW_VALID]
    |=> s_r.st == ST_HALT && !FILL_GO [*2]) else $error("invalid list not halted");
  a_halt_waits: assert property (s_r.st == ST_HALT && !recheck && s_r.en
    |=> s_r.st == ST_HALT && !FETCH_REQ && (s_r.stat & ~$past(s_r.stat)) == 2'h0)
    else $error("halt left without recheck");
  a_pause_waits: assert property (s_r.st == ST_PAUSE && !resume && s_r.en
    |=> s_r.st == ST_PAUSE && !FETCH_REQ && !FILL_GO) else $error("pause left early");
  a_resume_link: assert property (s_r.st == ST_PAUSE && resume && s_r.en
    |=> FETCH_REQ && FETCH_ADDR == $past(s_r.end_link)) else $error("wrong resume list");
  a_pause_entry: assert property (seq_frame_done ##0 s_r.start_pause
    |=> s_r.st == ST_PAUSE && s_r.stat[ST_FRAME_BIT]) else $error("pause not entered");
  a_frame_irq: assert property (seq_frame_done ##0 s_r.start_irq
    |=> s_r.stat[ST_FRAME_BIT]) else $error("frame interrupt lost");
  a_start_only: assert property (s_r.st == ST_FILL && FILL_DONE && !FILL_IN.sof
    |=> $stable(s_r.start_irq) && $stable(s_r.start_pause))
    else $error("request bits taken from non-start list");
  a_wb_start: assert property (WB_REQ && s_r.st == ST_WB_START
    |-> WB_OUT.word[LSW_COMPLETE] && !WB_OUT.word[LSW_VALID] && WB_OUT.word[LSW_START]
        && WB_OUT.word[LSW_FSB_HI:LSW_FSB_LO] == s_r.fsb[7:2]
        && WB_OUT.word[LSW_END] == s_r.end_sof) else $error("bad start word");
  a_wb_end: assert property (WB_REQ && s_r.st == ST_WB_END
    |-> WB_OUT.word[LSW_END] && !WB_OUT.word[LSW_START] && !WB_OUT.word[LSW_VALID]
        && WB_OUT.word[LSW_FSB_HI:LSW_FSB_LO] == 6'h00) else $error("bad end word");
  a_wb_reserved: assert property (WB_REQ
    |-> WB_OUT.word[7:4] == 4'h0 && WB_OUT.word[15:14] == 2'h0)
    else $error("reserved completion bits set");
  a_wb_after_eof: assert property ($rose(WB_REQ)
    |-> $past(s_r.st) == ST_FILL && $past(FILL_DONE) && $past(FILL_IN.eof)
        && WB_OUT.addr == ($past(FILL_IN.sof) ? $past(FETCH_ADDR) : s_r.start_addr))
    else $error("write-back not after frame end");

endmodule : rls_top

// File: verif/rls_host_model.sv
// Purpose: Host side model serving list fetch, fill and write-back handshakes
// Assumes: Eight lists at index*16 in a ring, each linked to the next
// Notes:   Stalls zero to three cycles after each answer
`timescale 1ns/1ps
module rls_host_model (
  input  wire logic             MCLK,
  input  wire logic             FETCH_REQ,
  input  wire logic [31:0]      FETCH_ADDR,
  output logic                  LIST_RSP,
  output rls_pkg::rls_list_t    LIST_IN,
  input  wire logic             FILL_GO,
  output logic                  FILL_DONE,
  output rls_pkg::rls_fill_t    FILL_IN,
  input  wire logic             WB_REQ,
  input  wire rls_pkg::rls_wb_t WB_OUT,
  output logic                  WB_ACK
);
  import rls_pkg::*;
  logic [15:0] word [8];
  logic        sof [8];
  logic        eof [8];
  logic [7:0]  fsb [8];
  logic [47:0] wbq [$];
  logic [2:0]  cur;
  logic        last_inv;
  logic        filling;
  int          dly;

  initial begin
    LIST_RSP = 1'h0;
    FILL_DONE = 1'h0;
    WB_ACK = 1'h0;
    LIST_IN = '0;
    FILL_IN = '0;
    last_inv = 1'h1;
    filling = 1'h0;
    dly = 0;
    foreach (word[i]) word[i] = 16'h0;
  end

  // ------------------------------------------------------------------
  // Handshake server; idle data lines toggle so stale values never match
  // ------------------------------------------------------------------
  always @(posedge MCLK) begin
    LIST_RSP <= 1'h0;
    FILL_DONE <= 1'h0;
    WB_ACK <= 1'h0;
    LIST_IN <= ~LIST_IN;
    FILL_IN <= ~FILL_IN;
    if (FILL_GO) begin
      filling <= 1'h1;
    end
    if (dly > 0) begin
      dly <= dly - 1;
    end else if (FETCH_REQ && !LIST_RSP) begin
      cur <= FETCH_ADDR[6:4];
      last_inv <= ~word[FETCH_ADDR[6:4]][0];
      LIST_IN <= '{FETCH_ADDR, word[FETCH_ADDR[6:4]], {25'h0, FETCH_ADDR[6:4] + 3'h1, 4'h0}};
      LIST_RSP <= 1'h1;
      dly <= $urandom_range(0, 3);
    end else if (filling) begin
      FILL_DONE <= 1'h1;
      FILL_IN <= '{sof[cur], eof[cur], fsb[cur]};
      filling <= 1'h0;
      dly <= $urandom_range(0, 3);
    end else if (WB_REQ && !WB_ACK) begin
      WB_ACK <= 1'h1;
      word[WB_OUT.addr[6:4]] <= WB_OUT.word;
      wbq.push_back(WB_OUT);
      dly <= $urandom_range(0, 3);
    end
  end
endmodule : rls_host_model

// File: verif/rx_list_status_word_tb.sv
// Purpose: Self-checking bench for the receive list status word engine
// Assumes: Host model serves the list handshakes; all lists start invalid
// Notes:   Each frame is released by a recheck and ends at an invalid list
`timescale 1ns/1ps
module rx_list_status_word_tb;
  import rls_pkg::*;
  logic        MCLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0]  PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, FETCH_ADDR, q, h;
  logic        PREADY, PSLVERR, IRQ, FETCH_REQ, LIST_RSP, FILL_GO, FILL_DONE, WB_REQ, WB_ACK, e;
  rls_list_t   LIST_IN;
  rls_fill_t   FILL_IN;
  rls_wb_t     WB_OUT;
  int          mismatches = 0, num_checks = 0, cur = 0;
  logic [7:0]  ofs [5] = '{OFS_CTRL, OFS_CMD, OFS_HEAD, OFS_STAT, OFS_MASK};

  always #10 MCLK = ~MCLK;

  rls_top i_rls_top (.MCLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .IRQ, .FETCH_REQ, .FETCH_ADDR, .LIST_RSP, .LIST_IN, .FILL_GO,
    .FILL_DONE, .FILL_IN, .WB_REQ, .WB_OUT, .WB_ACK);
  rls_host_model i_rls_host_model (.MCLK, .FETCH_REQ, .FETCH_ADDR, .LIST_RSP, .LIST_IN,
    .FILL_GO, .FILL_DONE, .FILL_IN, .WB_REQ, .WB_OUT, .WB_ACK);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] cw(input logic s, input logic n, input logic [7:0] f);
    return {2'h0, s ? f[7:2] : 6'h0, 4'h0, n, s, 2'h2};
  endfunction : cw

  task automatic chk(input string nm, input logic [47:0] x, input logic [47:0] y);
    num_checks++;
    if (y !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, x, y);
    end
  endtask : chk

  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic hang(input string nm);
    chk(nm, 1, 0);
    summarize();
  endtask : hang

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK) PENABLE <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge MCLK);
      if (PREADY === 1'h1) break;
    end
    if (n == 20) hang("pready");
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb

  task automatic halt();
    int t;
    for (t = 0; t < 300 && !(FETCH_REQ === 0 && i_rls_host_model.last_inv); t++) @(posedge MCLK);
    if (t == 300) hang("halt");
  endtask : halt

  // ------------------------------------------------------------------
  // One frame over n lists starting at cur
  // ------------------------------------------------------------------
  task automatic frame(input int n, input logic [15:0] rq, input logic [1:0] m);
    logic [7:0] f;
    logic [1:0] s;
    int j, k, t;
    f = 8'($urandom);
    s = {rq[5], rq[5] | rq[4]};
    apb(1, OFS_MASK, {30'h0, m});
    for (k = 0; k < n; k++) begin
      j = (cur + k) % 8;
      i_rls_host_model.word[j] = (k == 0) ? (rq | 16'h1) : 16'h31;
      i_rls_host_model.sof[j] = (k == 0);
      i_rls_host_model.eof[j] = (k == n - 1);
      i_rls_host_model.fsb[j] = f;
    end
    i_rls_host_model.word[(cur + n) % 8] = 16'h0;
    apb(1, OFS_CMD, 32'h1 << CMD_RECHECK_BIT);
    for (t = 0; t < 400 && (i_rls_host_model.wbq.size() < (n > 1 ? 2 : 1) || WB_REQ !== 0); t++)
      @(posedge MCLK);
    if (t == 400) hang("wb");
    repeat (2) @(posedge MCLK);
    chk("irq", |(s & m), IRQ);
    chk("wb_start", {32'(cur * 16), cw(1, n == 1, f)}, i_rls_host_model.wbq.pop_front());
    if (n > 1) chk("wb_end", {32'(((cur + n - 1) % 8) * 16), cw(0, 1, f)}, i_rls_host_model.wbq.pop_front());
    chk("wb_count", 0, i_rls_host_model.wbq.size());
    apb(0, OFS_STAT, 0);
    chk("stat", {30'h0, s}, q);
    apb(0, OFS_STAT, 0);
    chk("stat_clr", 0, {IRQ, q});
    if (rq[5]) begin
      apb(0, OFS_NEXT, 0);
      chk("next", 32'(((cur + n) % 8) * 16 + 1), q);
      for (t = 0; t < 20; t++) begin
        @(posedge MCLK);
        chk("pause_hold", 0, {FETCH_REQ, FILL_GO});
      end
      apb(1, OFS_CMD, 32'h1 << CMD_RESUME_BIT);
      for (t = 0; t < 50 && FETCH_REQ !== 1; t++) @(posedge MCLK);
      chk("resume", {1'h1, 32'(((cur + n) % 8) * 16)}, {FETCH_REQ, FETCH_ADDR});
    end
    cur = (cur + n) % 8;
    halt();
  endtask : frame

  always @(posedge MCLK) begin
    if (FILL_GO === 1'h1 && i_rls_host_model.last_inv) chk("fill_invalid", 0, 1);
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'h7927));
    repeat (16) @(posedge MCLK);
    RST_B <= 1;
    foreach (ofs[i]) begin
      apb(0, ofs[i], 0);
      chk("reset_val", 0, {e, q});
    end
    apb(0, 8'h18, 0);
    chk("unmapped", {1'h1, 32'h0}, {e, q});
    h = $urandom;
    apb(1, OFS_HEAD, h);
    apb(0, OFS_HEAD, 0);
    chk("head", h, q);
    apb(1, OFS_HEAD, 0);
    apb(1, OFS_CTRL, 1);
    halt();
    apb(0, OFS_STAT, 0);
    chk("halt_silent", 0, {IRQ, FILL_GO, q});
    frame(1, 16'h10, 2'h3);
    frame(3, 16'h0, 2'h3);
    frame(2, 16'h20, 2'h3);
    frame(1, 16'h10, 2'h0);
    frame(3, 16'h30, 2'h2);
    repeat (12) frame($urandom_range(1, 3), {10'h0, 2'($urandom), 4'h0}, 2'($urandom));
    apb(1, OFS_CTRL, 0);
    cur = (cur + 4) % 8;
    apb(1, OFS_HEAD, 32'(cur * 16));
    apb(1, OFS_CTRL, 1);
    repeat (2) @(posedge MCLK);
    halt();
    chk("restart", 32'(cur * 16), FETCH_ADDR);
    frame(2, 16'h30, 2'h1);
    summarize();
  end
endmodule : rx_list_status_word_tb
